// *** dv/sac_comp_model.sv ***
// Comparator model standing in for the sampled analog input.
`timescale 1ns/1ps
`default_nettype none
module sac_comp_model (
	// Trial code and held input.
	input  wire logic [11:0] dac_code,
	input  wire logic [11:0] vin_code,
	// Comparator decision.
	output logic             comp_hi
);
	// The input sits half a step inside its code, so a trial at or below it keeps the bit.
	assign comp_hi = (vin_code >= dac_code);
endmodule
`default_nettype wire

// *** dv/sac_core_checker.sv ***
// Assertion checker for the converter control core.
`timescale 1ns/1ps
`default_nettype none
module sac_core_checker (
	// Clock and reset.
	input wire logic        core_clk,
	input wire logic        rst,
	// Observed ports.
	input wire logic        ptr_wr,
	input wire logic [7:0]  ptr_data,
	input wire logic [15:0] reg_rdata,
	input wire logic [2:0]  ptr_value,
	input wire logic        sample_track,
	input wire logic        conv_done
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	property p_trk; $rose(sample_track) |-> ##99 sample_track; endproperty
	a_trk: assert property (p_trk) else $error("track phase too short");
	property p_trk_end; $rose(sample_track) |-> ##100 !sample_track; endproperty
	a_trk_end: assert property (p_trk_end) else $error("track phase too long");
	property p_done; conv_done |=> !conv_done; endproperty
	a_done: assert property (p_done) else $error("done longer than one cycle");
	property p_done_trk; sample_track |-> !conv_done; endproperty
	a_done_trk: assert property (p_done_trk) else $error("done while tracking");
	wire [2:0] ptr_sel = ptr_data[2:0];
	property p_ptr; ptr_wr |=> ptr_value == $past(ptr_sel); endproperty
	a_ptr: assert property (p_ptr) else $error("pointer not loaded");
	property p_ptr_hold; !ptr_wr |=> $stable(ptr_value); endproperty
	a_ptr_hold: assert property (p_ptr_hold) else $error("pointer moved");
	property p_res; ptr_value == 3'h0 && $past(ptr_value) == 3'h0 |-> reg_rdata[14:12] == 3'h0;
	endproperty
	a_res: assert property (p_res) else $error("result reserved bits set");
	property p_conv_len; $fell(sample_track) |-> ##12 !conv_done ##1 conv_done; endproperty
	a_conv_len: assert property (p_conv_len) else $error("balancing not twelve steps");
endmodule
bind sac_core sac_core_checker u_chk (
	.core_clk(core_clk), .rst(rst), .ptr_wr(ptr_wr), .ptr_data(ptr_data),
	.reg_rdata(reg_rdata), .ptr_value(ptr_value), .sample_track(sample_track),
	.conv_done(conv_done)
);
`default_nettype wire

// *** dv/sac_core_test.sv ***
// Self-checking testbench of the converter control core.
`timescale 1ns/1ps
`default_nettype none
module sac_core_test;
	logic core_clk = 1'b0, rst = 1'b1, ptr_wr = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
	logic [7:0]  ptr_data = 8'h00;
	logic [15:0] reg_wdata = 16'h0000;
	logic [11:0] vin = 12'h000;
	logic [15:0] reg_rdata;
	logic [11:0] dac_code;
	logic [2:0]  ptr_value;
	logic        comp_hi, sample_track, conv_done;
	int          fail_count = 0, n_tests = 0;
	always #2 core_clk = ~core_clk;
	sac_core dut (.core_clk(core_clk), .rst(rst), .ptr_wr(ptr_wr), .ptr_data(ptr_data),
		.reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.ptr_value(ptr_value), .comp_hi(comp_hi), .sample_track(sample_track),
		.dac_code(dac_code), .conv_done(conv_done));
	sac_comp_model u_cmp (.dac_code(dac_code), .vin_code(vin), .comp_hi(comp_hi));
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("FAIL %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic pulse(input int sel, input logic [15:0] v);
		ptr_wr <= (sel == 0);
		reg_wr <= (sel == 1);
		reg_rd <= (sel == 2);
		ptr_data <= v[7:0];
		reg_wdata <= v;
		@(posedge core_clk);
		{ptr_wr, reg_wr, reg_rd} <= 3'h0;
		repeat (2) @(posedge core_clk);
	endtask
	task automatic wait_done;
		@(negedge core_clk);
		for (int i = 0; i < 400 && conv_done !== 1'b1; i++) @(negedge core_clk);
		chk({15'h0, conv_done}, 16'h0001);
		repeat (2) @(posedge core_clk);
	endtask
	task automatic t_reset;
		chk({13'h0, ptr_value}, 16'h0000);
		for (int p = 0; p < 8; p++) begin
			pulse(0, 16'(p));
			chk(reg_rdata, (p == 6) ? 16'h0fff : 16'h0000);
		end
	endtask
	task automatic t_regs;
		for (int p = 3; p < 6; p++) begin
			pulse(0, 16'(p));
			chk({13'h0, ptr_value}, 16'(p));
			pulse(1, 16'h1110 + 16'(p));
			chk(reg_rdata, 16'h1110 + 16'(p));
		end
	endtask
	task automatic t_conv(input logic [11:0] v, input logic [11:0] lo, input logic [11:0] hi,
		input logic [1:0] st);
		vin <= v;
		pulse(0, 16'h0000);
		pulse(2, 16'h0000);
		wait_done();
		chk(reg_rdata, {4'h0, v});
		chk({4'h0, dac_code}, {4'h0, v});
		pulse(0, 16'h0001);
		chk(reg_rdata, {14'h0, st});
		pulse(0, 16'h0006);
		chk(reg_rdata, {4'h0, lo});
		pulse(0, 16'h0007);
		chk(reg_rdata, {4'h0, hi});
	endtask
	task automatic t_ro;
		pulse(0, 16'h0000);
		pulse(1, 16'h0abc);
		chk(reg_rdata, 16'h0fff);
	endtask
	task automatic t_auto;
		vin <= 12'h800;
		pulse(0, 16'h0002);
		pulse(1, 16'h0028);
		pulse(0, 16'h0000);
		wait_done();
		chk(reg_rdata, 16'h8800);
	endtask
	task automatic complete_run;
		$display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// Three conversions and the auto run take about 600 cycles; this leaves wide margin.
	initial begin
		#40000;
		fail_count++;
		complete_run();
	end
	initial begin
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		t_reset();
		t_regs();
		t_conv(12'h5a3, 12'h5a3, 12'h5a3, 2'b10);
		t_conv(12'h001, 12'h001, 12'h5a3, 2'b11);
		t_conv(12'hfff, 12'h001, 12'hfff, 2'b10);
		t_ro();
		t_auto();
		complete_run();
	end
endmodule
`default_nettype wire

// *** rtl/sac_core.sv ***
// Conversion control and register core of the 12-bit converter.
`timescale 1ns/1ps
`default_nettype none
module sac_core #(
	parameter int WIDTH = sac_pkg::RES_BITS
) (
	// Clock and reset.
	input  wire logic        core_clk,
	input  wire logic        rst,
	// Register access from the serial front end.
	input  wire logic        ptr_wr,
	input  wire logic [7:0]  ptr_data,
	input  wire logic        reg_wr,
	input  wire logic [15:0] reg_wdata,
	input  wire logic        reg_rd,
	output logic      [15:0] reg_rdata,
	output logic      [2:0]  ptr_value,
	// Analog front end.
	input  wire logic        comp_hi,
	output logic             sample_track,
	output logic      [11:0] dac_code,
	output logic             conv_done
);
	import sac_pkg::*;

	// Register file and read path.
	logic [2:0]  ptr_ff;
	logic [15:0] regs_ff [0:7];
	logic [15:0] rdata_ff;
	// Conversion sequencing.
	logic        track_ff;
	logic        done_ff;
	logic [7:0]  cnt_ff;
	logic        pend_ff;
	sac_state_t  state_ff;
	logic [11:0] trial;
	logic        sar_done;

	// Only the 12-bit layout of the result word is implemented.
	if (WIDTH != 12) begin : g_width_check
		$error("sac_core: only 12-bit results are supported");
	end
	// Both phase counts must fit the eight-bit down counter and be at least one.
	if (TRACK_CYCLES < 1 || TRACK_CYCLES > 255) begin : g_track_check
		$error("sac_core: track count does not fit the counter");
	end
	if (AUTO_GAP_CYCLES < 1 || AUTO_GAP_CYCLES > 255) begin : g_gap_check
		$error("sac_core: gap count does not fit the counter");
	end

	// Unsigned compare of two codes, shared by the limit and extreme checks.
	function automatic logic code_below(input logic [11:0] a, input logic [11:0] b);
		return a < b;
	endfunction

	// Sum of a code and the hysteresis, one bit wider so that it cannot wrap.
	function automatic logic [12:0] code_plus(input logic [11:0] a, input logic [11:0] b);
		return {1'b0, a} + {1'b0, b};
	endfunction

	// The stepper's final trial is the straight-binary result.
	wire [11:0] code     = trial;
	wire        auto_on  = |regs_ff[PTR_CONFIG][7:CFG_AUTO_LO];
	wire        rd_res   = reg_rd && (ptr_ff == PTR_RESULT);
	wire        starting = (state_ff == SAC_IDLE) && (pend_ff || rd_res || auto_on);
	wire        sar_go   = (state_ff == SAC_TRACK) && (cnt_ff == 8'h00);
	wire [11:0] hi_lim   = regs_ff[PTR_HILIM][11:0];
	wire [11:0] lo_lim   = regs_ff[PTR_LOLIM][11:0];
	wire [11:0] hyst     = regs_ff[PTR_HYST][11:0];
	wire        over     = code_below(hi_lim, code);
	wire        under    = code_below(code, lo_lim);
	// Self-clearing needs the code to leave the hysteresis band; the hold bit stops it.
	wire        over_clr = code_plus(code, hyst) < {1'b0, hi_lim};
	wire        undr_clr = {1'b0, code} > code_plus(lo_lim, hyst);
	wire        hold     = regs_ff[PTR_CONFIG][CFG_HOLD];
	// A conversion sets a flag, a written one clears it; when both fall together the set wins.
	wire [1:0]  st_now   = regs_ff[PTR_STATUS][1:0];
	wire [1:0]  st_wclr  = (reg_wr && ptr_ff == PTR_STATUS) ? reg_wdata[1:0] : 2'b00;
	wire [1:0]  st_keep  = st_now & ~st_wclr;
	wire        ov_next  = over || (st_keep[ST_OVER] && !(over_clr && !hold));
	wire        un_next  = under || (st_keep[ST_UNDER] && !(undr_clr && !hold));
	wire        flag_on  = regs_ff[PTR_CONFIG][CFG_ALERT_FLAG] && (ov_next || un_next);
	wire [15:0] res_word = {flag_on, 3'b000, code};

	// A conversion ends in the hold phase when the stepper reports its last bit.
	wire        store    = sar_done && (state_ff == SAC_HOLD);
	wire [11:0] lowest   = regs_ff[PTR_LOWEST][11:0];
	wire [11:0] highest  = regs_ff[PTR_HIGHST][11:0];
	wire        new_low  = code_below(code, lowest);
	wire        new_high = code_below(highest, code);

	// Successive-approximation stepper; it reports done together with its final code.
	sac_sar_step #(
		.WIDTH (12)
	) u_step (
		.core_clk   (core_clk),
		.rst        (rst),
		.start      (sar_go),
		.comp_hi    (comp_hi),
		.trial_code (trial),
		.done       (sar_done)
	);

	// Track, then balance; in automatic mode a short gap separates cycles.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state_ff <= SAC_IDLE;
			cnt_ff   <= 8'h00;
			track_ff <= 1'b0;
			pend_ff  <= 1'b0;
		end else begin
			// A result read during a conversion is served by one more conversion.
			if (rd_res && state_ff != SAC_IDLE) begin
				pend_ff <= 1'b1;
			end else if (starting) begin
				pend_ff <= 1'b0;
			end
			case (state_ff)
				SAC_IDLE: begin
					// Starts on a result read, a queued read, or in automatic mode.
					if (starting) begin
						state_ff <= SAC_TRACK;
						cnt_ff   <= 8'(TRACK_CYCLES - 1);
						track_ff <= 1'b1;
					end
				end
				SAC_TRACK: begin
					// The track phase lasts the full count; the stepper starts as it ends.
					if (cnt_ff == 8'h00) begin
						state_ff <= SAC_HOLD;
						track_ff <= 1'b0;
					end else begin
						cnt_ff <= cnt_ff - 8'h01;
					end
				end
				SAC_HOLD: begin
					// The stepper was started on the edge that left the track phase.
					if (sar_done) begin
						state_ff <= SAC_GAP;
						cnt_ff   <= 8'(AUTO_GAP_CYCLES - 1);
					end
				end
				SAC_GAP: begin
					// A queued read or leaving automatic mode cuts the gap short.
					if (cnt_ff == 8'h00 || pend_ff || !auto_on) begin
						state_ff <= SAC_IDLE;
					end else begin
						cnt_ff <= cnt_ff - 8'h01;
					end
				end
				default: begin
					state_ff <= SAC_IDLE;
					track_ff <= 1'b0;
				end
			endcase
		end
	end

	// The pointer takes the first byte of each write; only its low bits select.
	// Upper bits are dropped, so a byte with stray upper bits still selects a register.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ptr_ff <= PTR_RESULT;
		end else if (ptr_wr) begin
			ptr_ff <= ptr_data[2:0];
		end
	end

	// Register file; software writes and conversion updates share it.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < 8; i++) begin
				regs_ff[i] <= RST_ZERO;
			end
			// The lowest register starts at full scale so the first result replaces it.
			regs_ff[PTR_LOWEST] <= RST_LOWEST;
		end else begin
			// Writes to the result address are dropped; only a conversion changes it.
			if (reg_wr && ptr_ff != PTR_RESULT) begin
				regs_ff[ptr_ff] <= reg_wdata;
			end
			if (store) begin
				regs_ff[PTR_RESULT] <= res_word;
				regs_ff[PTR_STATUS] <= {14'h0000, ov_next, un_next};
				if (new_low) begin
					regs_ff[PTR_LOWEST] <= {4'h0, code};
				end
				if (new_high) begin
					regs_ff[PTR_HIGHST] <= {4'h0, code};
				end
			end else if (reg_wr && ptr_ff == PTR_STATUS) begin
				regs_ff[PTR_STATUS] <= {14'h0000, st_keep};
			end
		end
	end

	// Completion strobe, one cycle long, on the edge that stores the result.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			done_ff <= 1'b0;
		end else begin
			done_ff <= store;
		end
	end

	// Read data is registered; it follows the pointer one cycle late, and a read of the result address starts a conversion.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			rdata_ff <= RST_ZERO;
		end else begin
			rdata_ff <= regs_ff[ptr_ff];
		end
	end

	assign reg_rdata    = rdata_ff;
	assign ptr_value    = ptr_ff;
	assign sample_track = track_ff;
	// The stepper's code flop drives the converter directly, so the comparator always
	// answers for the trial that the stepper holds; a further register would skew it.
	assign dac_code     = trial;
	assign conv_done    = done_ff;
endmodule
`default_nettype wire

// *** rtl/sac_pkg.sv ***
// Package of constants and types for the converter control core.
// What this block does
// - Hold track phase about 0.4 us first.
// - Convert on result read or automatic mode.
// - Step trial code until balance, store result.
// - Unsigned straight binary over 4096 steps.
// - Power-on reset loads every register default.
// - First completed conversion updates result and status.
// - Eight data registers plus one pointer register.
// - All registers writable except result register.
// - Hold lowest, highest, thresholds and configuration.
// - First write byte sets pointer; three bits used.
// - Pointer order: result through highest conversion.
// - Result word: alert bit15, zeros, code 11:0.
package sac_pkg;
	localparam int RES_BITS        = 12;
	localparam int PTR_BITS        = 3;
	localparam int TRACK_NS        = 400;
	localparam int CLK_PERIOD_NS   = 4;
	localparam int TRACK_CYCLES    = TRACK_NS / CLK_PERIOD_NS;
	localparam int AUTO_GAP_CYCLES = 64;
	localparam logic [2:0] PTR_RESULT = 3'h0;
	localparam logic [2:0] PTR_STATUS = 3'h1;
	localparam logic [2:0] PTR_CONFIG = 3'h2;
	localparam logic [2:0] PTR_LOLIM  = 3'h3;
	localparam logic [2:0] PTR_HILIM  = 3'h4;
	localparam logic [2:0] PTR_HYST   = 3'h5;
	localparam logic [2:0] PTR_LOWEST = 3'h6;
	localparam logic [2:0] PTR_HIGHST = 3'h7;
	localparam logic [15:0] RST_ZERO   = 16'h0000;
	localparam logic [15:0] RST_LOWEST = 16'h0fff;
	localparam int ALERT_BIT       = 15;
	localparam int CFG_AUTO_LO     = 5;
	localparam int CFG_ALERT_FLAG  = 3;
	localparam int CFG_HOLD        = 4;
	localparam int ST_OVER         = 1;
	localparam int ST_UNDER        = 0;
	typedef enum logic [1:0] {SAC_IDLE, SAC_TRACK, SAC_HOLD, SAC_GAP} sac_state_t;
endpackage

// *** rtl/sac_sar_step.sv ***
// Successive-approximation trial code stepper.
`timescale 1ns/1ps
`default_nettype none
module sac_sar_step #(
	parameter int WIDTH = 12
) (
	// Clock and reset.
	input  wire logic             core_clk,
	input  wire logic             rst,
	// Control.
	input  wire logic             start,
	input  wire logic             comp_hi,
	// Results.
	output logic [WIDTH-1:0]      trial_code,
	output logic                  done
);
	logic [WIDTH-1:0] code_ff;
	logic [WIDTH-1:0] bit_ff;
	logic             done_ff;
	wire  [WIDTH-1:0] kept    = comp_hi ? code_ff : (code_ff & ~bit_ff);
	wire  [WIDTH-1:0] nxt_bit = bit_ff >> 1;
	wire  [WIDTH-1:0] msb     = {1'b1, {(WIDTH-1){1'b0}}};
	// A single-bit stepper would need a zero-width replication for its first trial code.
	if (WIDTH < 2) begin : g_width_check
		$error("sac_sar_step: WIDTH too small");
	end
	// The comparator answers for the bit set in the current trial code.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			code_ff <= '0;
			bit_ff  <= '0;
			done_ff <= 1'b0;
		end else if (start) begin
			code_ff <= msb;
			bit_ff  <= msb;
			done_ff <= 1'b0;
		end else if (bit_ff != '0) begin
			code_ff <= kept | nxt_bit;
			bit_ff  <= nxt_bit;
			done_ff <= (nxt_bit == '0);
		end else begin
			done_ff <= 1'b0;
		end
	end
	assign trial_code = code_ff;
	assign done       = done_ff;
endmodule
`default_nettype wire
